// >>> lgtc_pkg.sv
/*
 * lgtc_pkg: register map, field positions, reset values and mode
 * enumerations for the line interface global and transmit config bank.
 * Assumes a 32-bit APB slave with printed offsets scaled by four.
 */
package lgtc_pkg;
    localparam int LGTC_NUM_CH = 4;
    // printed offsets are register indices; byte address = index * 4
    localparam logic [7:0] LGTC_IDX_JITTER_ATTEN_CONFIG = 8'h01;
    localparam logic [7:0] LGTC_IDX_TRANSMIT_CONFIG_0 = 8'h02;
    localparam logic [7:0] LGTC_IDX_GLOBAL_CONFIG_0 = 8'h40;
    localparam logic [7:0] LGTC_IDX_GLOBAL_CONFIG_1 = 8'h60;
    localparam logic [7:0] LGTC_IDX_CHANNEL_INTERRUPT_INDICATION = 8'h80;
    localparam logic [7:0] LGTC_CH_STRIDE = 8'h40;
    localparam logic [7:0] LGTC_IDX_INT_STATUS = 8'h16;
    localparam logic [7:0] LGTC_IDX_INT_MASK = 8'h11;
    // global_config_0 fields
    localparam int LGTC_GC0_PIN_LSB = 0;
    localparam int LGTC_GC0_MASK_BIT = 2;
    localparam int LGTC_GC0_COPY_BIT = 3;
    localparam int LGTC_GC0_STD_BIT = 4;
    localparam logic [7:0] LGTC_GC0_RESET = 8'h04;
    localparam logic [7:0] LGTC_GC0_WMASK = 8'h3F;
    // global_config_1 fields
    localparam int LGTC_GC1_MON_LSB = 4;
    localparam logic [7:0] LGTC_GC1_RESET = 8'h00;
    localparam logic [7:0] LGTC_GC1_WMASK = 8'hF0;
    // jitter_atten_config fields
    localparam int LGTC_JA_BW_BIT = 0;
    localparam int LGTC_JA_DP_LSB = 1;
    localparam int LGTC_JA_PL_LSB = 3;
    localparam int LGTC_JA_LIM_BIT = 5;
    localparam logic [7:0] LGTC_JA_RESET = 8'h00;
    localparam logic [7:0] LGTC_JA_WMASK = 8'h3F;
    // transmit_config_0 fields, then the interrupt mask reset value
    localparam int LGTC_TX_MD_LSB = 0;
    localparam int LGTC_TX_EDGE_BIT = 2;
    localparam int LGTC_TX_POL_BIT = 3;
    localparam int LGTC_TX_OFF_BIT = 4;
    localparam logic [7:0] LGTC_TX_RESET = 8'h00;
    localparam logic [7:0] LGTC_TX_WMASK = 8'h1F;
    localparam logic [7:0] LGTC_MASK_RESET = 8'hFF;

    typedef enum logic [1:0] {LGTC_TX_HDB3_B8ZS, LGTC_TX_AMI, LGTC_TX_DUAL_RAIL} lgtc_tx_mode_t;
    typedef enum logic [1:0] {LGTC_JA_OFF, LGTC_JA_TX, LGTC_JA_RX} lgtc_ja_place_t;
    typedef enum logic [1:0] {LGTC_DEPTH_128, LGTC_DEPTH_64, LGTC_DEPTH_32} lgtc_depth_t;
    typedef enum logic [1:0] {LGTC_MON_NONE, LGTC_MON_RX, LGTC_MON_TX} lgtc_mon_kind_t;
    typedef enum logic [1:0] {LGTC_PIN_OD_LOW, LGTC_PIN_PP_LOW, LGTC_PIN_PP_HIGH} lgtc_pin_t;
endpackage : lgtc_pkg

// >>> lgtc_regs.sv
/*
 * lgtc_regs: APB register bank for global settings and per-channel
 * jitter attenuator and transmitter configuration of a four-channel
 * line interface, with interrupt aggregation and pin drive control.
 * Assumes one clock (pclk), async active-low reset, interrupt status
 * levels arriving from channel logic on the same clock.
 */
// Implementation choice: the APB interface to the registers.
// Functional notes
// [R1] line standard bit: 0 E1, 1 T1/J1
// [R2] broadcast mode copies writes to all channels
// [R3] global mask set suppresses all interrupts
// [R4] per-source masks gate interrupts when enabled
// [R5] pin style: x0 OD low, 01/11 push-pull
// [R6] monitor codes route receivers 2-4 to ch1
// [R7] monitor codes route transmitters 2-4; odd reserved
// [R8] codes 0000/1000 mean no monitoring
// [R9] indication flags on even bits, odd zero
// [R10] channel registers repeat at 0x40 stride
// [R11] limit bit selects wide bandwidth limit mode
// [R12] placement: off, transmit path, receive path
// [R13] depth: 128, 64 or 32 bits
// [R14] bandwidth bit selects low corner frequency
// [R15] power-down bit off and driver high-Z
// [R16] polarity bit inverts transmit data inputs
// [R17] edge bit: 0 falling, 1 rising sample
// [R18] mode 00 single rail, HDB3/B8ZS coding
// [R19] mode 01 single rail, AMI coding
// [R20] mode 1x dual rail, encoder bypassed
// [R21] software keeps reserved bit 5 zero
// [R22] flag follows pending unmasked channel status
`timescale 1ns/1ps
module lgtc_regs
    import lgtc_pkg::*;
#(
    parameter int NUM_CH = LGTC_NUM_CH
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources per channel, levels on pclk
    input wire logic [NUM_CH*8-1:0] int_status,
    // interrupt pin, two-signal form (level and output enable)
    output logic irq_out,
    output logic irq_oe,
    // global settings
    output logic line_standard_select,
    output logic [1:0] monitor_kind,
    output logic [1:0] monitor_channel,
    // per-channel jitter attenuator controls
    output logic [NUM_CH-1:0] jitter_limit_mode,
    output logic [NUM_CH*2-1:0] jitter_attenuator_placement,
    output logic [NUM_CH*2-1:0] jitter_buffer_depth,
    output logic [NUM_CH-1:0] jitter_bandwidth_select,
    // per-channel transmit controls
    output logic [NUM_CH-1:0] tx_power_down,
    output logic [NUM_CH-1:0] tx_driver_hiz,
    output logic [NUM_CH-1:0] tx_data_polarity,
    output logic [NUM_CH-1:0] tx_clock_edge_select,
    output logic [NUM_CH*2-1:0] tx_path_mode
);
    logic [7:0] gc0_r;
    logic [7:0] gc1_r;
    logic [7:0] ja_r [NUM_CH];
    logic [7:0] tx_r [NUM_CH];
    logic [7:0] im_r [NUM_CH];
    logic [7:0] flags_r;

    // one wait state; a write lands only on the edge that sees pready high
    wire logic acc = psel && penable;
    wire logic wr_acc = acc && pready && pwrite && pstrb[0];
    wire logic [9:0] idx = paddr[11:2];
    wire logic word_ok = paddr[1:0] == 2'b00 && idx[9:8] == 2'b00;
    wire logic [7:0] reg_idx = idx[7:0];
    wire logic [7:0] low_idx = {2'b00, reg_idx[5:0]}; // [R10]
    wire logic [1:0] ch_sel = reg_idx[7:6];
    wire logic copy_en = gc0_r[LGTC_GC0_COPY_BIT];
    wire logic hit_gc0 = word_ok && reg_idx == LGTC_IDX_GLOBAL_CONFIG_0;
    wire logic hit_gc1 = word_ok && reg_idx == LGTC_IDX_GLOBAL_CONFIG_1;
    wire logic hit_ind = word_ok && reg_idx == LGTC_IDX_CHANNEL_INTERRUPT_INDICATION;
    wire logic hit_ja = word_ok && low_idx == LGTC_IDX_JITTER_ATTEN_CONFIG;
    wire logic hit_tx = word_ok && low_idx == LGTC_IDX_TRANSMIT_CONFIG_0;
    wire logic hit_im = word_ok && low_idx == LGTC_IDX_INT_MASK;
    wire logic hit_is = word_ok && low_idx == LGTC_IDX_INT_STATUS;
    wire logic mapped = hit_gc0 || hit_gc1 || hit_ind || hit_ja || hit_tx || hit_im || hit_is;

    // per-channel write select: addressed channel, or all when copying
    function automatic logic ch_wr(input logic [1:0] sel, input int ch, input logic cp);
        ch_wr = cp || sel == 2'(ch); // [R2]
    endfunction : ch_wr

    // pending unmasked interrupt per channel
    logic [NUM_CH-1:0] pend;
    logic [7:0] ind_nxt;
    always_comb begin
        ind_nxt = 8'h00;
        for (int c = 0; c < NUM_CH; c++) begin
            pend[c] = |(int_status[c*8 +: 8] & ~im_r[c]); // [R4]
            ind_nxt[2*c] = pend[c]; // [R9] [R22]
        end
    end

    wire logic irq_any = !gc0_r[LGTC_GC0_MASK_BIT] && (|pend); // [R3]
    wire logic [1:0] pin_mode = gc0_r[LGTC_GC0_PIN_LSB +: 2];
    // open drain drives low only when asserted; push-pull always drives
    wire logic irq_lvl_nxt = (pin_mode == 2'b11) ? irq_any : !irq_any; // [R5]
    wire logic irq_oe_nxt = pin_mode[0] ? 1'b1 : irq_any; // [R5]

    // monitor decode; reserved odd codes fall back to no monitoring
    wire logic [3:0] mon = gc1_r[LGTC_GC1_MON_LSB +: 4];
    wire logic mon_act = !mon[0] && mon[2:1] != 2'b00; // [R6] [R7] [R8]
    wire logic [1:0] mon_kind_nxt = !mon_act ? 2'(LGTC_MON_NONE) :
        mon[3] ? 2'(LGTC_MON_TX) : 2'(LGTC_MON_RX); // [R6] [R7]
    wire logic [1:0] mon_ch_nxt = mon_act ? mon[2:1] : 2'b00; // [R8]

    wire logic [7:0] rd_ch = hit_ja ? ja_r[ch_sel] : hit_tx ? tx_r[ch_sel] :
        hit_im ? im_r[ch_sel] : hit_is ? int_status[ch_sel*8 +: 8] : 8'h00;
    wire logic [7:0] rd_byte = hit_gc0 ? gc0_r : hit_gc1 ? gc1_r :
        hit_ind ? flags_r : rd_ch;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gc0_r <= LGTC_GC0_RESET; // [R1] [R3]
            gc1_r <= LGTC_GC1_RESET; // [R8]
        end else if (wr_acc && hit_gc0) begin
            gc0_r <= pwdata[7:0] & LGTC_GC0_WMASK; // [R21]
        end else if (wr_acc && hit_gc1) begin
            gc1_r <= pwdata[7:0] & LGTC_GC1_WMASK;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire logic sel_g = ch_wr(ch_sel, g, copy_en);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ja_r[g] <= LGTC_JA_RESET;
                    tx_r[g] <= LGTC_TX_RESET;
                    im_r[g] <= LGTC_MASK_RESET;
                end else if (wr_acc && sel_g) begin
                    if (hit_ja) begin
                        ja_r[g] <= pwdata[7:0] & LGTC_JA_WMASK; // [R2]
                    end
                    if (hit_tx) begin
                        tx_r[g] <= pwdata[7:0] & LGTC_TX_WMASK; // [R2]
                    end
                    if (hit_im) begin
                        im_r[g] <= pwdata[7:0]; // [R2]
                    end
                end
            end

            wire logic [1:0] pl = ja_r[g][LGTC_JA_PL_LSB +: 2];
            wire logic [1:0] dp = ja_r[g][LGTC_JA_DP_LSB +: 2];
            wire logic [1:0] md = tx_r[g][LGTC_TX_MD_LSB +: 2];
            wire logic [1:0] pl_nxt = !pl[0] ? 2'(LGTC_JA_OFF) :
                pl[1] ? 2'(LGTC_JA_RX) : 2'(LGTC_JA_TX); // [R12]
            wire logic [1:0] dp_nxt = dp[1] ? 2'(LGTC_DEPTH_32) :
                dp[0] ? 2'(LGTC_DEPTH_64) : 2'(LGTC_DEPTH_128); // [R13]
            wire logic [1:0] md_nxt = md[1] ? 2'(LGTC_TX_DUAL_RAIL) :
                md[0] ? 2'(LGTC_TX_AMI) : 2'(LGTC_TX_HDB3_B8ZS); // [R18] [R19] [R20]

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    jitter_limit_mode[g] <= 1'b0;
                    jitter_attenuator_placement[g*2 +: 2] <= 2'(LGTC_JA_OFF);
                    jitter_buffer_depth[g*2 +: 2] <= 2'(LGTC_DEPTH_128);
                    jitter_bandwidth_select[g] <= 1'b0;
                    tx_power_down[g] <= 1'b0;
                    tx_driver_hiz[g] <= 1'b0;
                    tx_data_polarity[g] <= 1'b0;
                    tx_clock_edge_select[g] <= 1'b0;
                    tx_path_mode[g*2 +: 2] <= 2'(LGTC_TX_HDB3_B8ZS);
                end else begin
                    jitter_limit_mode[g] <= ja_r[g][LGTC_JA_LIM_BIT]; // [R11]
                    jitter_attenuator_placement[g*2 +: 2] <= pl_nxt; // [R12]
                    jitter_buffer_depth[g*2 +: 2] <= dp_nxt; // [R13]
                    jitter_bandwidth_select[g] <= ja_r[g][LGTC_JA_BW_BIT]; // [R14]
                    tx_power_down[g] <= tx_r[g][LGTC_TX_OFF_BIT]; // [R15]
                    tx_driver_hiz[g] <= tx_r[g][LGTC_TX_OFF_BIT]; // [R15]
                    tx_data_polarity[g] <= tx_r[g][LGTC_TX_POL_BIT]; // [R16]
                    tx_clock_edge_select[g] <= tx_r[g][LGTC_TX_EDGE_BIT]; // [R17]
                    tx_path_mode[g*2 +: 2] <= md_nxt; // [R18] [R19] [R20]
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= 8'h00;
            irq_out <= 1'b1;
            irq_oe <= 1'b0;
            line_standard_select <= 1'b0;
            monitor_kind <= 2'(LGTC_MON_NONE);
            monitor_channel <= 2'b00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            flags_r <= ind_nxt; // [R22]
            irq_out <= irq_lvl_nxt;
            irq_oe <= irq_oe_nxt;
            line_standard_select <= gc0_r[LGTC_GC0_STD_BIT]; // [R1]
            monitor_kind <= mon_kind_nxt;
            monitor_channel <= mon_ch_nxt;
            // one wait state: answer registered in first access cycle
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata <= (psel && penable && !pready && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end
endmodule : lgtc_regs

// >>> lgtc_regs_chk.sv
/* lgtc_regs_chk: port assertions for the config bank.
   Assumes one pclk domain; bound to lgtc_regs below. */
`timescale 1ns/1ps
module lgtc_regs_chk #(parameter int NUM_CH = 4) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // controls
    input wire logic line_standard_select,
    input wire logic [1:0] monitor_kind,
    input wire logic [1:0] monitor_channel,
    input wire logic [NUM_CH*2-1:0] jitter_attenuator_placement,
    input wire logic [NUM_CH*2-1:0] jitter_buffer_depth,
    input wire logic [NUM_CH*2-1:0] tx_path_mode,
    input wire logic [NUM_CH-1:0] tx_power_down,
    input wire logic [NUM_CH-1:0] tx_driver_hiz
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_answer; psel && penable && !pready |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("pready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held");
    property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero");
    property p_err; pslverr |-> pready && $past(psel && penable); endproperty
    a_err: assert property (p_err) else $error("stray pslverr");
    // change only after a write; the write lands once, and psel with pwrite stay high at both depths
    property p_std; $changed(line_standard_select) |->
        $past(psel && pwrite, 2) || $past(psel && pwrite, 3); endproperty
    a_std: assert property (p_std) else $error("standard changed alone");
    property p_hiz; tx_driver_hiz == tx_power_down; endproperty
    a_hiz: assert property (p_hiz) else $error("driver not off");
    property p_place; (jitter_attenuator_placement & (jitter_attenuator_placement >> 1)
        & {NUM_CH{2'b01}}) == '0; endproperty
    a_place: assert property (p_place) else $error("placement code 3");
    property p_depth; (jitter_buffer_depth & (jitter_buffer_depth >> 1)
        & {NUM_CH{2'b01}}) == '0; endproperty
    a_depth: assert property (p_depth) else $error("depth code 3");
    property p_mode; (tx_path_mode & (tx_path_mode >> 1) & {NUM_CH{2'b01}}) == '0;
    endproperty
    a_mode: assert property (p_mode) else $error("tx mode code 3");
    property p_mon; (monitor_kind == 2'h0) == (monitor_channel == 2'h0); endproperty
    a_mon: assert property (p_mon) else $error("monitor pair mismatch");
endmodule : lgtc_regs_chk
bind lgtc_regs lgtc_regs_chk #(.NUM_CH(NUM_CH)) u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .line_standard_select, .monitor_kind,
    .monitor_channel, .jitter_attenuator_placement, .jitter_buffer_depth, .tx_path_mode,
    .tx_power_down, .tx_driver_hiz);

// >>> lgtc_host.sv
/* lgtc_host: APB master standing for the host processor.
   Assumes pclk rising edge timing; a wait cut at 40 cycles. */
`timescale 1ns/1ps
module lgtc_host (
    // apb
    input wire logic pclk,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [11:0] paddr = 12'h0,
    output logic [31:0] pwdata = 32'h0,
    output logic [3:0] pstrb = 4'hF,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            // timed out: unknown response trips every caller's check
            rd = 32'hXXXX_XXXX;
            er = 1'bx;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data must not look valid
    endtask : xfer
endmodule : lgtc_host

// >>> tb_lineif_global_and_tx_config.sv
/* tb_lineif_global_and_tx_config: model-compared bench of lgtc_regs.
   Assumes lgtc_host as master and the checker bound to the design. */
`timescale 1ns/1ps
module tb_lineif_global_and_tx_config;
    import lgtc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, pready, pslverr, iro, ire, lss, er;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ist = 32'h0, lf = 32'hF4BC887C;
    logic [3:0] pstrb, jlm, jbw, tpd, thz, tpol, tedge;
    logic [1:0] mk, mc;
    logic [7:0] jpl, jdp, tmd, gc0, gc1, ja[4], tx[4], msk[4];
    int num_errors = 0, checks_done = 0, i;
    always #5 pclk = ~pclk;
    lgtc_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr);
    lgtc_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .int_status(ist), .irq_out(iro), .irq_oe(ire),
        .line_standard_select(lss), .monitor_kind(mk), .monitor_channel(mc),
        .jitter_limit_mode(jlm), .jitter_attenuator_placement(jpl),
        .jitter_buffer_depth(jdp), .jitter_bandwidth_select(jbw), .tx_power_down(tpd),
        .tx_driver_hiz(thz), .tx_data_polarity(tpol), .tx_clock_edge_select(tedge),
        .tx_path_mode(tmd));
    function logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nx
    function logic [1:0] enc(input logic [1:0] v, input bit pl);
        return pl ? (v == 2'h1 ? 2'h1 : v == 2'h3 ? 2'h2 : 2'h0) : (v[1] ? 2'h2 : v);
    endfunction : enc
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task results;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task wr(input int a, input logic [7:0] v);
        host.xfer(1'b1, 12'(a * 4), {24'h0, v}, rd, er);
        chk("wr_rsp", 8'h0, {7'h0, er});
        for (int c = 0; c < 4; c++) begin
            if (c == a / 64 || gc0[3]) begin
                if (a % 64 == 1) ja[c] = v & 8'h3F;
                if (a % 64 == 2) tx[c] = v & 8'h1F;
                if (a % 64 == 17) msk[c] = v;
            end
        end
        if (a == 64) gc0 = v & 8'h3F;
        if (a == 96) gc1 = v & 8'hF0;
    endtask : wr
    task rc(input string n, input int a, input logic [7:0] e);
        host.xfer(1'b0, 12'(a * 4), 32'h0, rd, er);
        chk(n, e, rd[7:0]);
        chk("rsp", 8'h0, {6'h0, |rd[31:8], er});
    endtask : rc
    task outs;
        logic [7:0] j, t, ind;
        logic a;
        ind = 8'h0;
        repeat (3) @(posedge pclk);
        for (int c = 0; c < 4; c++) begin
            j = ja[c];
            t = tx[c];
            ind[2 * c] = |(ist[8 * c +: 8] & ~msk[c]);
            chk("ja", {j[5], j[0], enc(j[4:3], 1), enc(j[2:1], 0), enc(t[1:0], 0)},
                {jlm[c], jbw[c], jpl[2*c+:2], jdp[2*c+:2], tmd[2*c+:2]});
            chk("tx", {4'h0, t[4], t[4], t[3:2]}, {4'h0, tpd[c], thz[c], tpol[c], tedge[c]});
            rc("ja_rd", c * 64 + 1, j);
            rc("tx_rd", c * 64 + 2, t);
        end
        chk("std", {7'h0, gc0[4]}, {7'h0, lss});
        a = !(gc1[4] || gc1[6:5] == 2'h0);
        chk("mon", a ? {4'h0, (gc1[7] ? 2'h2 : 2'h1), gc1[6:5]} : 8'h0,
            {4'h0, mk, mc});
        a = !gc0[2] && ind != 8'h0;
        chk("irq", {6'h0, gc0[0] | a, gc0[0] & (gc0[1] ~^ a)}, {6'h0, ire, ire & iro});
        rc("ind", 128, ind);
        rc("gc0", 64, gc0);
        rc("gc1", 96, gc1);
    endtask : outs
    initial begin
        gc0 = 8'h04;
        gc1 = 8'h0;
        ja = '{4{8'h0}};
        tx = '{4{8'h0}};
        msk = '{4{8'hFF}};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        outs();
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            wr(i % 4 * 64 + 1, lf[7:0]);
            wr(i % 4 * 64 + 2, lf[15:8]);
            wr(64, lf[23:16] & 8'hD7);
            lf = nx(lf);
            outs();
        end
        $display("test channel config done");
        for (i = 0; i < 16; i++) begin
            wr(96, {i[3:0], lf[3:0]});
            lf = nx(lf);
            outs();
        end
        $display("test monitor done");
        wr(64, gc0 | 8'h08);
        wr(130, lf[7:0]);
        wr(129, lf[15:8]);
        wr(145, lf[23:16]);
        wr(64, gc0 & 8'hF7);
        host.xfer(1'b0, 12'h00C, 32'h0, rd, er);
        chk("unmapped", 8'h01, {7'h0, er});
        wr(128, 8'hFF);
        outs();
        $display("test broadcast and refusal done");
        for (i = 0; i < 8; i++) begin
            wr(17 + i % 4 * 64, lf[31:24] & 8'h0F);
            wr(64, {3'h0, gc0[4], 1'b0, i[2:0]});
            ist <= lf | 32'h1;
            lf = nx(lf);
            outs();
        end
        ist <= 32'h0;
        outs();
        $display("test interrupts done");
        results();
    end
    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule : tb_lineif_global_and_tx_config
